// ---- hw/cpos_pkg.sv ----
// Package of constants and types for the cluster monitor overflow and select registers.
package cpos_pkg;
   localparam int unsigned CPOS_DATA_W = 64;
   localparam int unsigned CPOS_NUM_CTR = 6;
   localparam int unsigned CPOS_SEL_W = 5;
   localparam int unsigned CPOS_CNT_W = 5;
   localparam logic [4:0] CPOS_SEL_CYCLE = 5'h1f;
   localparam logic [5:0] CPOS_OVF_RESET = 6'h00;
   localparam logic [4:0] CPOS_SEL_RESET = 5'h00;
   localparam logic [5:0] CPOS_SYNDROME_CLASS = 6'h18;
   // Register selector codes on the access port.
   localparam logic [1:0] CPOS_REG_OVS_CLR = 2'h0;
   localparam logic [1:0] CPOS_REG_SELECT = 2'h1;
   localparam logic [1:0] CPOS_REG_XEVTYPE = 2'h2;
   localparam logic [1:0] CPOS_REG_XEVCNT = 2'h3;
   // Privilege level encodings.
   localparam logic [1:0] CPOS_PL_USER = 2'h0;
   localparam logic [1:0] CPOS_PL_OS = 2'h1;
   localparam logic [1:0] CPOS_PL_HYP = 2'h2;
   localparam logic [1:0] CPOS_PL_MON = 2'h3;
   // Access outcome codes.
   localparam logic [1:0] CPOS_RES_OK = 2'h0;
   localparam logic [1:0] CPOS_RES_UNDEF = 2'h1;
   localparam logic [1:0] CPOS_RES_TRAP_HYP = 2'h2;
   localparam logic [1:0] CPOS_RES_TRAP_MON = 2'h3;
   typedef enum logic [1:0] {
      CPOS_ST_IDLE = 2'b01,
      CPOS_ST_DONE = 2'b10
   } cpos_state_t;
endpackage

// ---- hw/cpos_regs.sv ----
// Overflow status clear and counter select registers with privilege gating.
`timescale 1ns/1ps
`default_nettype none
module cpos_regs
   import cpos_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Counter events
   input wire logic [CPOS_NUM_CTR-1:0] ctr_overflow_i,
   input wire logic [CPOS_CNT_W-1:0] ctr_accessible_i,
   // Access request
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [1:0] acc_reg_i,
   input wire logic [CPOS_DATA_W-1:0] acc_wdata_i,
   // Privilege and enables
   input wire logic [1:0] current_privilege_level_i,
   input wire logic hyp_enabled_i,
   input wire logic hyp_impdef_reg_trap_i,
   input wire logic hyp_cluster_monitor_enable_i,
   input wire logic monitor_cluster_monitor_enable_i,
   input wire logic debug_halted_i,
   input wire logic secure_debug_disabled_i,
   input wire logic sdd_monitor_trap_priority_i,
   // Indirect counter side
   input wire logic [CPOS_DATA_W-1:0] ind_rdata_i,
   output logic ind_valid_o,
   output logic ind_write_o,
   output logic ind_is_count_o,
   output logic [CPOS_SEL_W-1:0] ind_index_o,
   output logic [CPOS_DATA_W-1:0] ind_wdata_o,
   // Access answer
   output logic acc_done_o,
   output logic [1:0] acc_result_o,
   output logic [5:0] acc_syndrome_o,
   output logic [CPOS_DATA_W-1:0] acc_rdata_o,
   // State view
   output logic [CPOS_NUM_CTR-1:0] ovf_flags_o,
   output logic [CPOS_SEL_W-1:0] select_o
);
   logic [CPOS_NUM_CTR-1:0] ovf_ff;
   logic [CPOS_SEL_W-1:0] sel_ff;
   logic [1:0] res;
   logic ok;
   logic sel_oor;
   logic [CPOS_NUM_CTR-1:0] clr_mask;
   cpos_state_t state_ff;

   // Decide the outcome of an access from privilege and enable bits.
   function automatic logic [1:0] access_result(input logic [1:0] pl, input logic wr);
      logic [1:0] r;
      r = CPOS_RES_OK;
      unique case (pl)
         CPOS_PL_USER: r = CPOS_RES_UNDEF;
         CPOS_PL_OS: begin
            if (hyp_enabled_i && hyp_impdef_reg_trap_i) begin
               r = CPOS_RES_TRAP_HYP;
            end else if (wr && debug_halted_i && secure_debug_disabled_i &&
                         sdd_monitor_trap_priority_i && !monitor_cluster_monitor_enable_i) begin
               r = CPOS_RES_UNDEF;
            end else if (wr && hyp_enabled_i && !hyp_cluster_monitor_enable_i) begin
               r = CPOS_RES_TRAP_HYP;
            end else if (wr && !monitor_cluster_monitor_enable_i) begin
               r = (debug_halted_i && secure_debug_disabled_i) ? CPOS_RES_UNDEF
                                                              : CPOS_RES_TRAP_MON;
            end
         end
         CPOS_PL_HYP: begin
            if (wr && !monitor_cluster_monitor_enable_i) begin
               r = (debug_halted_i && secure_debug_disabled_i) ? CPOS_RES_UNDEF
                                                              : CPOS_RES_TRAP_MON;
            end
         end
         CPOS_PL_MON: r = CPOS_RES_OK;
      endcase
      return r;
   endfunction

   assign res = access_result(current_privilege_level_i, acc_write_i);
   assign ok = acc_valid_i && (res == CPOS_RES_OK);
   // Index 31 is the cycle counter slot and stays visible.
   assign sel_oor = (sel_ff >= ctr_accessible_i) && (sel_ff != CPOS_SEL_CYCLE);
   assign clr_mask = (ok && acc_write_i && acc_reg_i == CPOS_REG_OVS_CLR)
                     ? acc_wdata_i[CPOS_NUM_CTR-1:0] : '0;

   // Set wins over clear so an overflow in the clearing cycle is kept.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ovf_ff <= CPOS_OVF_RESET;
      end else begin
         ovf_ff <= (ovf_ff & ~clr_mask) | ctr_overflow_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sel_ff <= CPOS_SEL_RESET;
      end else if (ok && acc_write_i && acc_reg_i == CPOS_REG_SELECT && !sel_oor) begin
         sel_ff <= acc_wdata_i[CPOS_SEL_W-1:0];
      end
   end

   // Each request is answered one cycle later; the done state closes it.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_ff <= CPOS_ST_IDLE;
         acc_done_o <= 1'b0;
         acc_result_o <= CPOS_RES_OK;
         acc_syndrome_o <= 6'h00;
         acc_rdata_o <= '0;
         ind_valid_o <= 1'b0;
         ind_write_o <= 1'b0;
         ind_is_count_o <= 1'b0;
         ind_index_o <= CPOS_SEL_RESET;
         ind_wdata_o <= '0;
      end else begin
         acc_done_o <= acc_valid_i;
         state_ff <= acc_valid_i ? CPOS_ST_DONE : CPOS_ST_IDLE;
         acc_result_o <= acc_valid_i ? res : CPOS_RES_OK;
         acc_syndrome_o <= (acc_valid_i && res[1]) ? CPOS_SYNDROME_CLASS : 6'h00;
         ind_valid_o <= ok && acc_reg_i[1] && !sel_oor;
         ind_write_o <= acc_write_i;
         ind_is_count_o <= acc_reg_i == CPOS_REG_XEVCNT;
         ind_index_o <= sel_ff;
         ind_wdata_o <= acc_wdata_i;
         acc_rdata_o <= '0;
         if (ok && !acc_write_i) begin
            unique case (acc_reg_i)
               CPOS_REG_OVS_CLR: acc_rdata_o <= {{(CPOS_DATA_W-CPOS_NUM_CTR){1'b0}}, ovf_ff};
               CPOS_REG_SELECT: acc_rdata_o <= sel_oor ? '0 :
                                  {{(CPOS_DATA_W-CPOS_SEL_W){1'b0}}, sel_ff};
               default: acc_rdata_o <= sel_oor ? '0 : ind_rdata_i;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ovf_flags_o <= CPOS_OVF_RESET;
         select_o <= CPOS_SEL_RESET;
      end else begin
         ovf_flags_o <= (ovf_ff & ~clr_mask) | ctr_overflow_i;
         select_o <= sel_ff;
      end
   end

   // Answers are checked one edge after the request is taken.
   sticky_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ctr_overflow_i[0] |=> ovf_ff[0])
      else $error("overflow not captured");
   clear_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
      clr_mask[1] && !ctr_overflow_i[1] |=> !ovf_ff[1])
      else $error("flag not cleared");
   zero_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !clr_mask[2] && ovf_ff[2] |=> ovf_ff[2])
      else $error("flag lost");
   ovs_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && !acc_write_i && acc_reg_i == CPOS_REG_OVS_CLR &&
      current_privilege_level_i == CPOS_PL_MON
      |=> state_ff == CPOS_ST_DONE &&
          acc_rdata_o == {{(CPOS_DATA_W-CPOS_NUM_CTR){1'b0}}, $past(ovf_ff)})
      else $error("overflow status read wrong");
   user_undef_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && current_privilege_level_i == CPOS_PL_USER |=> acc_result_o == CPOS_RES_UNDEF)
      else $error("user access not undefined");
   os_trap_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && current_privilege_level_i == CPOS_PL_OS && hyp_enabled_i &&
      hyp_impdef_reg_trap_i |=> acc_result_o == CPOS_RES_TRAP_HYP &&
      acc_syndrome_o == CPOS_SYNDROME_CLASS)
      else $error("missing hypervisor trap");
   hyp_enable_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && acc_write_i && current_privilege_level_i == CPOS_PL_OS && hyp_enabled_i &&
      !hyp_impdef_reg_trap_i && !hyp_cluster_monitor_enable_i && monitor_cluster_monitor_enable_i
      |=> acc_result_o == CPOS_RES_TRAP_HYP)
      else $error("write not trapped");
   mon_trap_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && acc_write_i && current_privilege_level_i == CPOS_PL_HYP &&
      !monitor_cluster_monitor_enable_i && !debug_halted_i |=> acc_result_o == CPOS_RES_TRAP_MON)
      else $error("monitor trap missing");
   prio_undef_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && acc_write_i && current_privilege_level_i == CPOS_PL_OS &&
      !hyp_impdef_reg_trap_i && debug_halted_i && secure_debug_disabled_i &&
      sdd_monitor_trap_priority_i && !monitor_cluster_monitor_enable_i
      |=> acc_result_o == CPOS_RES_UNDEF)
      else $error("halted write not undefined");
   mon_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && current_privilege_level_i == CPOS_PL_MON |=> acc_result_o == CPOS_RES_OK)
      else $error("monitor access refused");
   hyp_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && !acc_write_i && current_privilege_level_i == CPOS_PL_HYP
      |=> acc_result_o == CPOS_RES_OK)
      else $error("hypervisor read refused");
   oor_inert_a: assert property (@(posedge clk_i) disable iff (reset_i)
      sel_oor |=> !ind_valid_o)
      else $error("indirect access while out of range");
   ind_index_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ok && acc_reg_i[1] && !sel_oor |=> ind_valid_o && ind_index_o == $past(sel_ff))
      else $error("indirect index not forwarded");
   sel_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ok && acc_write_i && acc_reg_i == CPOS_REG_SELECT && !sel_oor
      |=> sel_ff == $past(acc_wdata_i[4:0]))
      else $error("select not written");
   clr_cov: cover property (@(posedge clk_i) disable iff (reset_i) clr_mask != '0);
   trap_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      acc_done_o && acc_result_o[1]);
   ind_cov: cover property (@(posedge clk_i) disable iff (reset_i) ind_valid_o);
   prio_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      acc_valid_i && sdd_monitor_trap_priority_i && res == CPOS_RES_UNDEF);
endmodule // cpos_regs
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the overflow status and counter select registers.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cpos_pkg::*;
   logic clk_i, reset_i, acc_valid_i, acc_write_i;
   logic ind_valid_o, ind_write_o, ind_is_count_o;
   // Control bits, high to low: priority, hyp on, trap, hyp enable, mon enable, halted, sdd.
   logic [6:0] ctl;
   logic [5:0] ctr_overflow_i, acc_syndrome_o, ovf_flags_o;
   logic [4:0] ctr_accessible_i, select_o, ind_index_o;
   logic [1:0] acc_reg_i, pl, acc_result_o;
   logic [63:0] acc_wdata_i, ind_rdata_i, acc_rdata_o, ind_wdata_o;
   logic acc_done_o;
   int n_mismatch = 0;
   int total_checks = 0;
   cpos_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .ctr_overflow_i(ctr_overflow_i),
      .ctr_accessible_i(ctr_accessible_i), .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i),
      .acc_reg_i(acc_reg_i), .acc_wdata_i(acc_wdata_i), .current_privilege_level_i(pl),
      .hyp_enabled_i(ctl[5]), .hyp_impdef_reg_trap_i(ctl[4]),
      .hyp_cluster_monitor_enable_i(ctl[3]), .monitor_cluster_monitor_enable_i(ctl[2]),
      .debug_halted_i(ctl[1]), .secure_debug_disabled_i(ctl[0]),
      .sdd_monitor_trap_priority_i(ctl[6]), .ind_rdata_i(ind_rdata_i),
      .ind_valid_o(ind_valid_o), .ind_write_o(ind_write_o), .ind_is_count_o(ind_is_count_o),
      .ind_index_o(ind_index_o), .ind_wdata_o(ind_wdata_o),
      .acc_done_o(acc_done_o), .acc_result_o(acc_result_o), .acc_syndrome_o(acc_syndrome_o),
      .acc_rdata_o(acc_rdata_o), .ovf_flags_o(ovf_flags_o), .select_o(select_o));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One access; the answer is awaited for a few cycles only, so a hang is caught.
   task automatic acc(input logic w, input logic [1:0] r, input logic [1:0] p,
         input logic [63:0] wd, input logic [1:0] er, input logic [63:0] ed);
      int i;
      @(posedge clk_i);
      acc_valid_i <= 1'b1;
      acc_write_i <= w;
      acc_reg_i <= r;
      pl <= p;
      acc_wdata_i <= wd;
      @(posedge clk_i);
      acc_valid_i <= 1'b0;
      #1;
      for (i = 0; i < 4 && acc_done_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      if (acc_done_o !== 1'b1) begin
         n_mismatch++;
         close_out();
      end else begin
         check(64'(acc_result_o), 64'(er));
         check(64'(acc_syndrome_o), 64'((er >= 2'h2) ? CPOS_SYNDROME_CLASS : 6'h00));
         check(acc_rdata_o, (w || er != CPOS_RES_OK) ? 64'h0 : ed);
      end
   endtask
   // Forwarded indirect access, seen in the same cycle as the answer.
   task automatic ind_chk(input logic [7:0] e, input logic [63:0] wd);
      check(64'({ind_valid_o, ind_write_o, ind_is_count_o, ind_index_o}), 64'(e));
      check(ind_wdata_o, wd);
   endtask
   task automatic setc(input logic [6:0] c, input logic [4:0] n);
      @(posedge clk_i);
      ctl <= c;
      ctr_accessible_i <= n;
   endtask
   task automatic ovf(input logic [5:0] m);
      @(posedge clk_i);
      ctr_overflow_i <= m;
      @(posedge clk_i);
      ctr_overflow_i <= 6'h00;
   endtask
   initial begin
      reset_i = 1'b1;
      acc_valid_i = 1'b0;
      acc_write_i = 1'b0;
      acc_reg_i = 2'h0;
      pl = 2'h0;
      acc_wdata_i = 64'h0;
      ind_rdata_i = 64'h1234_5678_9abc_def0;
      ctr_overflow_i = 6'h00;
      ctl = 7'h04;
      ctr_accessible_i = 5'h06;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check(64'(select_o), 64'h0);
      ovf(6'h25);
      ovf(6'h01);
      acc(1'b0, CPOS_REG_OVS_CLR, CPOS_PL_HYP, 64'h0, CPOS_RES_OK, 64'h25);
      acc(1'b1, CPOS_REG_OVS_CLR, CPOS_PL_MON, 64'h1, CPOS_RES_OK, 64'h0);
      acc(1'b0, CPOS_REG_OVS_CLR, CPOS_PL_MON, 64'h0, CPOS_RES_OK, 64'h24);
      acc(1'b1, CPOS_REG_OVS_CLR, CPOS_PL_OS, 64'hffff_ffff_ffff_ffc4, CPOS_RES_OK, 64'h0);
      acc(1'b0, CPOS_REG_OVS_CLR, CPOS_PL_HYP, 64'h0, CPOS_RES_OK, 64'h20);
      acc(1'b0, CPOS_REG_OVS_CLR, CPOS_PL_USER, 64'h0, CPOS_RES_UNDEF, 64'h0);
      setc(7'h34, 5'h06);
      acc(1'b0, CPOS_REG_OVS_CLR, CPOS_PL_OS, 64'h0, CPOS_RES_TRAP_HYP, 64'h0);
      setc(7'h24, 5'h06);
      acc(1'b1, CPOS_REG_OVS_CLR, CPOS_PL_OS, 64'h20, CPOS_RES_TRAP_HYP, 64'h0);
      setc(7'h08, 5'h06);
      acc(1'b1, CPOS_REG_OVS_CLR, CPOS_PL_HYP, 64'h20, CPOS_RES_TRAP_MON, 64'h0);
      setc(7'h0b, 5'h06);
      acc(1'b1, CPOS_REG_OVS_CLR, CPOS_PL_HYP, 64'h20, CPOS_RES_UNDEF, 64'h0);
      setc(7'h63, 5'h06);
      acc(1'b1, CPOS_REG_OVS_CLR, CPOS_PL_OS, 64'h20, CPOS_RES_UNDEF, 64'h0);
      setc(7'h23, 5'h06);
      acc(1'b1, CPOS_REG_OVS_CLR, CPOS_PL_OS, 64'h20, CPOS_RES_TRAP_HYP, 64'h0);
      acc(1'b0, CPOS_REG_OVS_CLR, CPOS_PL_HYP, 64'h0, CPOS_RES_OK, 64'h20);
      acc(1'b1, CPOS_REG_SELECT, CPOS_PL_MON, 64'hffff_ffff_ffff_ffe4, CPOS_RES_OK,
          64'h0);
      setc(7'h0c, 5'h06);
      acc(1'b0, CPOS_REG_SELECT, CPOS_PL_OS, 64'h0, CPOS_RES_OK, 64'h4);
      acc(1'b0, CPOS_REG_XEVCNT, CPOS_PL_OS, 64'h0, CPOS_RES_OK, ind_rdata_i);
      ind_chk(8'ha4, 64'h0);
      acc(1'b0, CPOS_REG_XEVTYPE, CPOS_PL_OS, 64'h0, CPOS_RES_OK, ind_rdata_i);
      ind_chk(8'h84, 64'h0);
      acc(1'b1, CPOS_REG_XEVTYPE, CPOS_PL_OS, 64'h11, CPOS_RES_OK, 64'h0);
      ind_chk(8'hc4, 64'h11);
      setc(7'h0c, 5'h03);
      acc(1'b0, CPOS_REG_SELECT, CPOS_PL_OS, 64'h0, CPOS_RES_OK, 64'h0);
      acc(1'b0, CPOS_REG_XEVCNT, CPOS_PL_OS, 64'h0, CPOS_RES_OK, 64'h0);
      ind_chk(8'h24, 64'h0);
      acc(1'b1, CPOS_REG_XEVCNT, CPOS_PL_OS, 64'h55, CPOS_RES_OK, 64'h0);
      ind_chk(8'h64, 64'h55);
      acc(1'b1, CPOS_REG_SELECT, CPOS_PL_OS, 64'h1, CPOS_RES_OK, 64'h0);
      repeat (2) @(posedge clk_i);
      #1;
      check(64'(select_o), 64'h4);
      check(64'(ovf_flags_o), 64'h20);
      close_out();
   end
endmodule // tb
`default_nettype wire
